/* logic/tis_level_filter.sv */
// Level wake filter clocked by watchdog oscillator ticks.
// Assumes the tick and level inputs are synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module tis_level_filter import tis_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_enable,
    input wire logic i_wdt_tick,
    input wire logic i_level_low,
    output logic o_level_ok
);
    logic [1:0] seen_reg;

    // Counts successive low samples and drops at once when the level goes away.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_reg <= 2'h0;
        end else if (!i_enable || !i_level_low) begin
            seen_reg <= 2'h0;
        end else if (i_wdt_tick && seen_reg != 2'h2) begin
            seen_reg <= seen_reg + 2'h1;
        end
    end

    assign o_level_ok = (seen_reg == 2'h2);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_level_two_ticks: assert property ($rose(o_level_ok) |-> $past(i_wdt_tick))
        else $error("level wake accepted without a watchdog sample");
endmodule
`default_nettype wire

/* logic/tis_pkg.sv */
// Package for the timer flag, interrupt sequencing and sleep control block.
// Assumes one 8-bit register port and a core that reports instruction boundaries.
package tis_pkg;
    localparam int TIS_AW = 8;
    localparam int TIS_DW = 8;
    localparam int TIS_SRC = 6;
    localparam int TIS_STW = 16;

    localparam logic [7:0] TIS_OFS_FLAGS = 8'h00;
    localparam logic [7:0] TIS_OFS_MASK = 8'h01;
    localparam logic [7:0] TIS_OFS_CORE = 8'h02;
    localparam logic [7:0] TIS_OFS_CPUF = 8'h03;
    localparam logic [7:0] TIS_OFS_ASYNC = 8'h04;
    localparam logic [7:0] TIS_OFS_STATE = 8'h05;

    localparam int TIS_BIT_CAP = 5;
    localparam int TIS_BIT_CMPA = 4;
    localparam int TIS_BIT_CMPB = 3;
    localparam int TIS_BIT_WOVF = 2;
    localparam int TIS_BIT_T0CMP = 1;
    localparam int TIS_BIT_T0OVF = 0;
    localparam int TIS_BIT_SE = 5;
    localparam int TIS_BIT_SM_HI = 4;
    localparam int TIS_BIT_SM_LO = 3;
    localparam int TIS_BIT_GIE = 7;
    localparam int TIS_BIT_AS0 = 3;

    localparam logic [7:0] TIS_RST_FLAGS = 8'h00;
    localparam logic [7:0] TIS_RST_MASK = 8'h00;
    localparam logic [7:0] TIS_RST_CORE = 8'h00;
    localparam logic [7:0] TIS_RST_CPUF = 8'h00;
    localparam logic [7:0] TIS_RST_ASYNC = 8'h00;

    localparam logic [3:0] TIS_ENTRY_CYC = 4'h4;
    localparam logic [3:0] TIS_JUMP_CYC = 4'h3;
    localparam logic [3:0] TIS_RET_CYC = 4'h4;
    localparam logic [1:0] TIS_HIDE_EXT = 2'h2;
    localparam logic [1:0] TIS_HIDE_TMR = 2'h3;

    typedef enum logic [1:0] {
        TIS_SM_IDLE = 2'b00,
        TIS_SM_RSVD = 2'b01,
        TIS_SM_DOWN = 2'b10,
        TIS_SM_SAVE = 2'b11
    } tis_mode_t;

    typedef enum logic [2:0] {
        TIS_ST_RUN = 3'b000,
        TIS_ST_ENTRY = 3'b001,
        TIS_ST_JUMP = 3'b010,
        TIS_ST_RETURN = 3'b011,
        TIS_ST_SLEEP = 3'b100,
        TIS_ST_WAKE = 3'b101
    } tis_state_t;

    typedef struct packed {
        logic capture;
        logic cmp_a;
        logic cmp_b;
        logic wide_ovf;
        logic wide_pwm;
        logic wide_leave_zero;
        logic t0_cmp;
        logic t0_ovf;
        logic t0_pwm;
        logic t0_leave_zero;
    } tis_events_t;
endpackage

/* logic/tis_top.sv */
// Timer event flags, interrupt entry and return timing, and sleep control.
// Assumes a core that pulses instruction boundary, sleep and return events.
// How it works
// - Capture event sets flag bit five.
// - Vector execution or written one clears flag.
// - Take only when global, source enable, flag.
// - Compare A match sets flag bit four.
// - Compare B match sets flag bit three.
// - Wide overflow bit two; pulse mode leaves zero.
// - Timer zero compare sets flag bit one.
// - Timer zero overflow bit zero; pulse variant.
// - Entry four cycles, two pushes, then vector.
// - Vector jump takes three cycles.
// - Finish multi-cycle instruction before entry.
// - Return four cycles, two pops.
// - One main instruction after return first.
// - Sleep needs enable bit; field picks mode.
// - Enabled interrupt wakes; state kept, resume.
// - Reset during sleep wakes to reset vector.
// - Idle halts processor only, wakes immediately.
// - Power down stops oscillator; limited wakers.
// - Level wake needs two watchdog samples.
// - Power down wake waits start-up period.
// - Vanished wake condition runs no interrupt.
// - Power save adds async timer zero wake.
// - Flags hidden two or three instructions.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module tis_top import tis_pkg::*; #(
    parameter logic [TIS_STW-1:0] P_STARTUP_0 = 16'h0010,
    parameter logic [TIS_STW-1:0] P_STARTUP_1 = 16'h0100,
    parameter logic [TIS_STW-1:0] P_STARTUP_2 = 16'h1000,
    parameter logic [TIS_STW-1:0] P_STARTUP_3 = 16'h4000
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [TIS_AW-1:0] i_addr,
    input wire logic [TIS_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [TIS_DW-1:0] o_rdata,
    input wire tis_events_t i_events,
    input wire logic i_instr_boundary,
    input wire logic i_sleep_instr,
    input wire logic i_reti,
    input wire logic i_ext_irq,
    input wire logic i_ext_level_low,
    input wire logic i_wdt_tick,
    input wire logic [1:0] i_startup_time_fuses,
    output logic o_cpu_hold,
    output logic o_push_pc,
    output logic o_pop_pc,
    output logic o_vector_exec,
    output logic [2:0] o_vector_id,
    output logic o_handler_start,
    output logic o_osc_stop,
    output logic o_ext_wake
);
    tis_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [TIS_STW-1:0] wait_reg;
    logic [TIS_SRC-1:0] timer_event_flag_reg;
    logic [TIS_SRC-1:0] timer_irq_mask_reg;
    logic [7:0] core_control_reg;
    logic cpu_gie_reg;
    logic t0_async_select;
    logic [TIS_DW-1:0] rdata_reg;
    logic [2:0] vec_reg;
    logic one_instr_reg;
    logic [1:0] hide_reg;
    tis_mode_t mode_reg;
    logic level_src_reg;
    logic hold_reg, push_reg, pop_reg, vexec_reg, hstart_reg, osc_reg, extw_reg;
    logic [TIS_SRC-1:0] ev;
    logic [TIS_SRC-1:0] ev_ok;
    logic [TIS_SRC-1:0] pending;
    logic [TIS_SRC-1:0] w1c;
    logic [TIS_SRC-1:0] vclr;
    logic level_ok;
    logic t0_wake;
    logic take;
    logic sleep_go;
    logic ps_asleep;
    logic [TIS_STW-1:0] startup_cnt;

    function automatic logic [2:0] tis_pick(input logic [TIS_SRC-1:0] p);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 0; k < TIS_SRC; k++) begin
            if (p[k]) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction

    tis_level_filter u_level (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_enable(state_reg == TIS_ST_SLEEP || state_reg == TIS_ST_WAKE),
        .i_wdt_tick(i_wdt_tick),
        .i_level_low(i_ext_level_low),
        .o_level_ok(level_ok)
    );

    assign ev[TIS_BIT_CAP] = i_events.capture;
    assign ev[TIS_BIT_CMPA] = i_events.cmp_a;
    assign ev[TIS_BIT_CMPB] = i_events.cmp_b;
    assign ev[TIS_BIT_WOVF] = i_events.wide_pwm ? i_events.wide_leave_zero
                                                : i_events.wide_ovf;
    assign ev[TIS_BIT_T0CMP] = i_events.t0_cmp;
    assign ev[TIS_BIT_T0OVF] = i_events.t0_pwm ? i_events.t0_leave_zero
                                               : i_events.t0_ovf;

    // With the oscillator stopped only an asynchronous timer zero still counts.
    assign ps_asleep = (state_reg == TIS_ST_SLEEP || state_reg == TIS_ST_WAKE)
                       && mode_reg != TIS_SM_IDLE && mode_reg != TIS_SM_RSVD;
    assign ev_ok = ps_asleep ? (ev & {4'h0, {2{mode_reg == TIS_SM_SAVE && t0_async_select}}})
                             : ev;

    assign w1c = (i_wr && i_addr == TIS_OFS_FLAGS) ? i_wdata[TIS_SRC-1:0] : '0;
    assign vclr = (state_reg == TIS_ST_ENTRY && cnt_reg == TIS_ENTRY_CYC - 4'h1)
                  ? (TIS_SRC'(1) << vec_reg) : '0;
    assign pending = timer_event_flag_reg & timer_irq_mask_reg;
    assign take = i_instr_boundary && cpu_gie_reg && (|pending) && hide_reg == 2'h0
                  && !one_instr_reg;
    assign sleep_go = i_sleep_instr && core_control_reg[TIS_BIT_SE];
    assign t0_wake = mode_reg == TIS_SM_SAVE && t0_async_select
                     && (|(pending & 6'h03));
    assign startup_cnt = (i_startup_time_fuses == 2'h0) ? P_STARTUP_0 :
                         (i_startup_time_fuses == 2'h1) ? P_STARTUP_1 :
                         (i_startup_time_fuses == 2'h2) ? P_STARTUP_2 : P_STARTUP_3;

    // Set wins over both clears; a written zero keeps the flag.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_event_flag_reg <= TIS_RST_FLAGS[TIS_SRC-1:0];
        end else begin
            timer_event_flag_reg <= (timer_event_flag_reg & ~w1c & ~vclr) | ev_ok;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_irq_mask_reg <= TIS_RST_MASK[TIS_SRC-1:0];
            core_control_reg <= TIS_RST_CORE;
            t0_async_select <= TIS_RST_ASYNC[TIS_BIT_AS0];
        end else if (i_wr) begin
            if (i_addr == TIS_OFS_MASK) begin
                timer_irq_mask_reg <= i_wdata[TIS_SRC-1:0];
            end else if (i_addr == TIS_OFS_CORE) begin
                core_control_reg <= i_wdata & 8'h38;
            end else if (i_addr == TIS_OFS_ASYNC) begin
                t0_async_select <= i_wdata[TIS_BIT_AS0];
            end
        end
    end

    // Entry masks further interrupts; return unmasks them again.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_gie_reg <= TIS_RST_CPUF[TIS_BIT_GIE];
        end else if (vclr != '0) begin
            cpu_gie_reg <= 1'b0;
        end else if (state_reg == TIS_ST_RETURN && cnt_reg == TIS_RET_CYC - 4'h1) begin
            cpu_gie_reg <= 1'b1;
        end else if (i_wr && i_addr == TIS_OFS_CPUF) begin
            cpu_gie_reg <= i_wdata[TIS_BIT_GIE];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= 8'h00;
        end else if (!i_rd) begin
            rdata_reg <= 8'h00;
        end else if (i_addr == TIS_OFS_FLAGS) begin
            rdata_reg <= (hide_reg != 2'h0) ? 8'h00 : {2'h0, timer_event_flag_reg};
        end else if (i_addr == TIS_OFS_MASK) begin
            rdata_reg <= {2'h0, timer_irq_mask_reg};
        end else if (i_addr == TIS_OFS_CORE) begin
            rdata_reg <= core_control_reg;
        end else if (i_addr == TIS_OFS_CPUF) begin
            rdata_reg <= {cpu_gie_reg, 7'h00};
        end else if (i_addr == TIS_OFS_ASYNC) begin
            rdata_reg <= {4'h0, t0_async_select, 3'h0};
        end else if (i_addr == TIS_OFS_STATE) begin
            rdata_reg <= {3'h0, hide_reg, state_reg};
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // The first main-program instruction after a return clears the hold-off.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            one_instr_reg <= 1'b0;
        end else if (state_reg == TIS_ST_RETURN && cnt_reg == TIS_RET_CYC - 4'h1) begin
            one_instr_reg <= 1'b1;
        end else if (state_reg == TIS_ST_RUN && i_instr_boundary) begin
            one_instr_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hide_reg <= 2'h0;
        end else if (state_reg == TIS_ST_WAKE && wait_reg == '0 && mode_reg == TIS_SM_SAVE) begin
            hide_reg <= level_src_reg ? TIS_HIDE_EXT : TIS_HIDE_TMR;
        end else if (state_reg == TIS_ST_RUN && i_instr_boundary && hide_reg != 2'h0) begin
            hide_reg <= hide_reg - 2'h1;
        end
    end

    // Sequencer for entry, jump, return, sleep and wake; reset returns to run.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= TIS_ST_RUN;
            cnt_reg <= 4'h0;
            wait_reg <= '0;
            vec_reg <= 3'h0;
            mode_reg <= TIS_SM_IDLE;
            level_src_reg <= 1'b0;
        end else begin
            case (state_reg)
                TIS_ST_RUN: begin
                    cnt_reg <= 4'h0;
                    if (take) begin
                        state_reg <= TIS_ST_ENTRY;
                        vec_reg <= tis_pick(pending);
                    end else if (i_reti) begin
                        state_reg <= TIS_ST_RETURN;
                    end else if (sleep_go) begin
                        state_reg <= TIS_ST_SLEEP;
                        mode_reg <= tis_mode_t'(core_control_reg[TIS_BIT_SM_HI:TIS_BIT_SM_LO]);
                    end
                end
                TIS_ST_ENTRY: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == TIS_ENTRY_CYC - 4'h1) begin
                        state_reg <= TIS_ST_JUMP;
                        cnt_reg <= 4'h0;
                    end
                end
                TIS_ST_JUMP: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == TIS_JUMP_CYC - 4'h1) begin
                        state_reg <= TIS_ST_RUN;
                    end
                end
                TIS_ST_RETURN: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == TIS_RET_CYC - 4'h1) begin
                        state_reg <= TIS_ST_RUN;
                    end
                end
                TIS_ST_SLEEP: begin
                    if (mode_reg == TIS_SM_IDLE || mode_reg == TIS_SM_RSVD) begin
                        if ((|pending) || i_ext_irq) begin
                            state_reg <= TIS_ST_RUN;
                        end
                    end else if (level_ok || t0_wake) begin
                        state_reg <= TIS_ST_WAKE;
                        wait_reg <= startup_cnt;
                        level_src_reg <= level_ok;
                    end
                end
                TIS_ST_WAKE: begin
                    if (level_src_reg && !level_ok && !t0_wake) begin
                        state_reg <= TIS_ST_SLEEP;
                    end else if (wait_reg == '0) begin
                        state_reg <= TIS_ST_RUN;
                    end else begin
                        wait_reg <= wait_reg - TIS_STW'(1);
                    end
                end
                default: begin
                    state_reg <= TIS_ST_RUN;
                end
            endcase
        end
    end

    // Registered strobes toward the core.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_reg <= 1'b0;
            push_reg <= 1'b0;
            pop_reg <= 1'b0;
            vexec_reg <= 1'b0;
            hstart_reg <= 1'b0;
            osc_reg <= 1'b0;
            extw_reg <= 1'b0;
        end else begin
            hold_reg <= state_reg != TIS_ST_RUN;
            push_reg <= state_reg == TIS_ST_ENTRY && cnt_reg < 4'h2;
            pop_reg <= state_reg == TIS_ST_RETURN && cnt_reg < 4'h2;
            vexec_reg <= vclr != '0;
            hstart_reg <= state_reg == TIS_ST_JUMP && cnt_reg == TIS_JUMP_CYC - 4'h1;
            osc_reg <= state_reg == TIS_ST_SLEEP && mode_reg[1];
            extw_reg <= state_reg == TIS_ST_WAKE && wait_reg == '0 && level_src_reg
                        && level_ok;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_cpu_hold = hold_reg;
    assign o_push_pc = push_reg;
    assign o_pop_pc = pop_reg;
    assign o_vector_exec = vexec_reg;
    assign o_vector_id = vec_reg;
    assign o_handler_start = hstart_reg;
    assign o_osc_stop = osc_reg;
    assign o_ext_wake = extw_reg;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_entry;
        (state_reg == TIS_ST_ENTRY) [*4] ##1 (state_reg == TIS_ST_JUMP);
    endsequence
    sequence s_jump;
        (state_reg == TIS_ST_JUMP) [*3] ##1 (state_reg == TIS_ST_RUN);
    endsequence
    sequence s_ret;
        (state_reg == TIS_ST_RETURN) [*4] ##1 (state_reg == TIS_ST_RUN);
    endsequence

    a_entry_then_jump: assert property ($rose(state_reg == TIS_ST_ENTRY)
        |-> s_entry ##0 s_jump)
        else $error("entry or jump length wrong");
    a_return_length: assert property ($rose(state_reg == TIS_ST_RETURN) |-> s_ret)
        else $error("return length wrong");
    a_take_needs_all: assert property (state_reg == TIS_ST_RUN ##1 state_reg == TIS_ST_ENTRY
        |-> $past(cpu_gie_reg && (|pending) && i_instr_boundary))
        else $error("interrupt taken without enables");
    a_two_pushes: assert property ($rose(state_reg == TIS_ST_ENTRY)
        |=> o_push_pc [*2] ##1 !o_push_pc)
        else $error("program counter push count wrong");
    a_set_wins: assert property (ev_ok[TIS_BIT_CAP] |=> timer_event_flag_reg[TIS_BIT_CAP])
        else $error("capture event lost");
    a_zero_write_keeps: assert property (i_wr && i_addr == TIS_OFS_FLAGS && vclr == '0
        |=> ($past(timer_event_flag_reg) & ~$past(i_wdata[TIS_SRC-1:0])
        & ~timer_event_flag_reg) == '0)
        else $error("zero write cleared a flag");
    a_sleep_needs_se: assert property (state_reg == TIS_ST_RUN
        ##1 state_reg == TIS_ST_SLEEP |-> $past(i_sleep_instr && core_control_reg[TIS_BIT_SE]))
        else $error("sleep without enable bit");
    a_one_after_ret: assert property (state_reg == TIS_ST_RETURN
        ##1 state_reg == TIS_ST_RUN |-> !take)
        else $error("interrupt served right after return");
    a_vector_clears: assert property ($rose(o_vector_exec)
        |-> !timer_event_flag_reg[vec_reg] || $past(ev_ok[vec_reg]))
        else $error("vector did not clear its flag");
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the timer flag, interrupt sequencing and sleep block.
// Assumes the core model drives instruction boundaries and the bench drives all else.
`timescale 1ns/1ns
`default_nettype none
module tb import tis_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    tis_events_t evr = '0;
    logic [2:0] pv = 3'h0;
    logic ext = 1'b0;
    logic lvl = 1'b0;
    logic multi = 1'b0;
    logic bnd, hold, push, pop, vec, hs, osc, xw;
    logic [2:0] vid;
    int mismatches = 0;
    int n_compared = 0;
    int n_push = 0;
    int n_pop = 0;
    int n_wake = 0;
    int t, p, w;
    logic [9:0] evs [8] = '{10'h200, 10'h100, 10'h080, 10'h040,
        10'h008, 10'h004, 10'h030, 10'h003};
    logic [7:0] fl [8] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h04, 8'h01};

    always #2 clk = ~clk;

    tis_top #(.P_STARTUP_0(16'h0004)) uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_events(evr),
        .i_instr_boundary(bnd), .i_sleep_instr(pv[0]), .i_reti(pv[1]), .i_ext_irq(ext),
        .i_ext_level_low(lvl), .i_wdt_tick(pv[2]), .i_startup_time_fuses(2'b00),
        .o_cpu_hold(hold), .o_push_pc(push), .o_pop_pc(pop), .o_vector_exec(vec),
        .o_vector_id(vid), .o_handler_start(hs), .o_osc_stop(osc), .o_ext_wake(xw));

    tis_core_model core (.i_clk_sys(clk), .i_rst_n(rst_n), .i_hold(hold), .i_multi(multi),
        .o_boundary(bnd));

    always @(posedge clk) begin
        n_push <= n_push + int'(push === 1'b1);
        n_pop <= n_pop + int'(pop === 1'b1);
        n_wake <= n_wake + int'(xw === 1'b1);
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic ev(input logic [9:0] v);
        @(posedge clk);
        evr <= v;
        @(posedge clk);
        evr <= '0;
    endtask

    task automatic pls(input logic [2:0] m);
        @(posedge clk);
        pv <= m;
        @(posedge clk);
        pv <= 3'h0;
    endtask

    task automatic wait_low(input logic which);
        t = 0;
        while ((which ? hold : !vec) && t < 60) begin
            cyc(1);
            t++;
        end
    endtask

    task automatic t_regs;
        rdc(TIS_OFS_FLAGS, TIS_RST_FLAGS);
        rdc(TIS_OFS_MASK, TIS_RST_MASK);
        rdc(TIS_OFS_CORE, TIS_RST_CORE);
        rdc(TIS_OFS_CPUF, TIS_RST_CPUF);
        rdc(TIS_OFS_ASYNC, TIS_RST_ASYNC);
        wreg(8'h40, 8'hff);
        rdc(8'h40, 8'h00);
        for (int k = 0; k < 8; k++) begin
            ev(evs[k]);
            rdc(TIS_OFS_FLAGS, fl[k]);
            wreg(TIS_OFS_FLAGS, ~fl[k]);
            rdc(TIS_OFS_FLAGS, fl[k]);
            wreg(TIS_OFS_FLAGS, fl[k]);
            rdc(TIS_OFS_FLAGS, 8'h00);
        end
        ev(10'h060);
        ev(10'h006);
        rdc(TIS_OFS_FLAGS, 8'h00);
        $display("Test registers and flags done");
    endtask

    task automatic t_irq;
        wreg(TIS_OFS_MASK, 8'h02);
        ev(10'h008);
        cyc(10);
        chk(8'(vec), 8'h00);
        p = n_push;
        wreg(TIS_OFS_CPUF, 8'h80);
        wait_low(1'b0);
        chk(8'(t >= 4), 8'h01);
        chk(8'(n_push - p), 8'h02);
        chk({5'h00, vid}, 8'h01);
        t = 0;
        while (hs !== 1'b1 && t < 20) begin
            cyc(1);
            t++;
        end
        chk(8'(t), 8'h03);
        rdc(TIS_OFS_FLAGS, 8'h00);
        ev(10'h008);
        p = n_pop;
        pls(3'b010);
        wait_low(1'b0);
        chk(8'(n_pop - p), 8'h02);
        chk(8'(vec), 8'h01);
        cyc(10);
        $display("Test interrupt entry and return done");
    endtask

    task automatic t_sleep;
        wreg(TIS_OFS_CORE, 8'h00);
        pls(3'b001);
        cyc(4);
        chk(8'(hold), 8'h00);
        wreg(TIS_OFS_CORE, 8'h20);
        pls(3'b001);
        cyc(4);
        chk({osc, hold}, 8'h01);
        ev(10'h008);
        cyc(3);
        chk(8'(hold), 8'h00);
        wreg(TIS_OFS_FLAGS, 8'h02);
        pls(3'b001);
        cyc(4);
        @(posedge clk);
        ext <= 1'b1;
        cyc(3);
        chk(8'(hold), 8'h00);
        @(posedge clk);
        ext <= 1'b0;
        wreg(TIS_OFS_CORE, 8'h30);
        pls(3'b001);
        cyc(4);
        ev(10'h008);
        cyc(4);
        chk({osc, hold}, 8'h03);
        @(posedge clk);
        lvl <= 1'b1;
        pls(3'b100);
        cyc(6);
        chk(8'(hold), 8'h01);
        w = n_wake;
        pls(3'b100);
        wait_low(1'b1);
        chk(8'(t >= 4), 8'h01);
        cyc(2);
        chk(8'(n_wake - w), 8'h01);
        @(posedge clk);
        lvl <= 1'b0;
        pls(3'b001);
        cyc(4);
        @(posedge clk);
        lvl <= 1'b1;
        pls(3'b100);
        pls(3'b100);
        lvl <= 1'b0;
        w = n_wake;
        cyc(12);
        chk({n_wake[6:0] - w[6:0], hold}, 8'h01);
        @(posedge clk);
        rst_n <= 1'b0;
        cyc(2);
        @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
        chk({osc, hold}, 8'h00);
        $display("Test sleep modes done");
    endtask

    task automatic t_save;
        @(posedge clk);
        multi <= 1'b1;
        wreg(TIS_OFS_ASYNC, 8'h08);
        wreg(TIS_OFS_MASK, 8'h02);
        wreg(TIS_OFS_CORE, 8'h38);
        pls(3'b001);
        cyc(4);
        chk({osc, hold}, 8'h03);
        ev(10'h008);
        wait_low(1'b1);
        chk(8'(hold), 8'h00);
        rdc(TIS_OFS_FLAGS, 8'h00);
        cyc(12);
        rdc(TIS_OFS_FLAGS, 8'h02);
        wreg(TIS_OFS_CPUF, 8'h80);
        wait_low(1'b0);
        chk({4'h0, vec, vid}, 8'h09);
        cyc(4);
        pls(3'b001);
        cyc(4);
        @(posedge clk);
        lvl <= 1'b1;
        pls(3'b100);
        pls(3'b100);
        wait_low(1'b1);
        rdc(TIS_OFS_STATE, 8'h10);
        $display("Test power save done");
    endtask

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        t_regs();
        t_irq();
        t_sleep();
        t_save();
        stop_test();
    end
endmodule
`default_nettype wire

/* tb/tis_core_model.sv */
// Core stand-in that reports instruction boundaries to the sleep and interrupt block.
// Assumes the block stalls it through its hold output; a halted core reports nothing.
`timescale 1ns/1ns
`default_nettype none
module tis_core_model (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_hold,
    input wire logic i_multi,
    output logic o_boundary
);
    logic phase_reg;

    // Multi-cycle instructions report their boundary only on their last cycle.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_reg <= 1'b0;
            o_boundary <= 1'b0;
        end else begin
            phase_reg <= i_multi ? ~phase_reg : 1'b0;
            o_boundary <= !i_hold && (!i_multi || phase_reg);
        end
    end
endmodule
`default_nettype wire
